// *** rtl/flash_host_ctrl.sv ***
// Host controller that issues command sequences to a parallel NOR flash and polls status
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

// Functional notes
// - F0 write returns device to array read
// - Identify: two unlocks, 90, then read
// - Program: two unlocks, A0, then data
// - Bypass entry via 20; short program
// - Bypass exit: 90 then 00
// - Sector erase: six writes, 30 at sector
// - Suspend B0 only during sector erase
// - Program polling: inverse bit until done
// - Erase polling reads 0, then 1
// - After completion, take data next read
// - Re-read polling bit after timeout seen
// - Chip erase polled at unprotected address; code polls at the command's address as given
// - Chip erase: six writes, others ignored
module flash_host_ctrl
	import flash_host_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic                     cmdValid,
	output logic                          cmdReady,
	input  wire cmd_s                     cmd,
	input  wire logic                     byteMode,
	output logic                          rspValid,
	output rsp_s                          rsp,
	output logic                          bypassMode,
	output logic                          suspendedMode,
	output logic                          busyStatus,
	output logic [`FLASH_ADDR_W-1:0]      flashAddr,
	input  wire logic [`FLASH_DATA_W-1:0] dqIn,
	output logic [`FLASH_DATA_W-1:0]      dqOut,
	output logic                          dqOe,
	output logic                          ceN,
	output logic                          weN,
	output logic                          oeN,
	input  wire logic                     readyBusyN
);

	// ==========================================================
	// Declarations
	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_ISSUE = 2'b01,
		S_WAIT  = 2'b10
	} state_e;

	typedef enum logic [2:0] {
		PH_WR      = 3'b000,
		PH_FINAL   = 3'b001,
		PH_POLL    = 3'b010,
		PH_CONFIRM = 3'b011,
		PH_RESET   = 3'b100
	} phase_e;

	state_e                   state;       // Controller state
	phase_e                   phase;       // What the current bus cycle is for
	logic [2:0]               step;        // Write index inside a sequence
	cmd_s                     cur;         // Operation in progress
	logic                     expectBit;   // Polling bit value meaning done
	logic                     sawTimeout;  // Timeout bit seen on last poll
	logic                     eraseActive; // A sector or chip erase is outstanding
	logic                     rbMeta;      // First sync stage of ready/busy
	logic                     rbSync;      // Second sync stage of ready/busy
	seq_s                     seq;         // Current sequence write
	logic                     takeSuspend; // Suspend accepted mid erase polling
	logic                     refuse;      // Operation not legal in present mode
	bus_req_s                 busReq;      // Cycle request to the engine
	logic                     busReqValid;
	logic                     busReqReady;
	logic                     busDone;
	logic [`FLASH_DATA_W-1:0] busRd;

	// ==========================================================
	// Functions
	// Write number 'step' of the sequence for 'op'; command data keeps
	// the upper byte zero and command addresses keep high bits zero, except the sector erase write at the sector address
	function automatic seq_s seqStep(input op_e op, input logic [2:0] st,
		input logic byp, input logic bm,
		input logic [`FLASH_ADDR_W-1:0] a, input logic [`FLASH_DATA_W-1:0] d);
		logic [`FLASH_ADDR_W-1:0] a1;
		logic [`FLASH_ADDR_W-1:0] a2;
		seq_s                     s;
		a1 = bm ? `ADR_UNLOCK1_BYTE : `ADR_UNLOCK1_WORD;
		a2 = bm ? `ADR_UNLOCK2_BYTE : `ADR_UNLOCK2_WORD;
		s  = '{addr: a1, data: {8'h00, `CMD_UNLOCK1}, last: 1'b0};
		if (st == 3'd1 || st == 3'd4) begin
			s.addr = a2;
			s.data = {8'h00, `CMD_UNLOCK2};
		end
		case (op)
			OP_PROGRAM: begin
				if (byp) begin
					s.addr = (st == 3'd0) ? 19'h00000 : a;
					s.data = (st == 3'd0) ? {8'h00, `CMD_PROGRAM} : d;
					s.last = (st == 3'd1);
				end else if (st == 3'd2) begin
					s.data = {8'h00, `CMD_PROGRAM};
				end else if (st == 3'd3) begin
					s = '{addr: a, data: d, last: 1'b1};
				end
			end
			OP_AUTOSEL, OP_VERIFY: begin
				if (st == 3'd2) begin
					s.data = {8'h00, `CMD_AUTOSELECT};
					s.last = 1'b1;
				end
			end
			OP_BYP_ENTER: begin
				if (st == 3'd2) begin
					s.data = {8'h00, `CMD_BYPASS};
					s.last = 1'b1;
				end
			end
			OP_CHIP_ERASE, OP_SECT_ERASE: begin
				if (st == 3'd2) begin
					s.data = {8'h00, `CMD_ERASE_SETUP};
				end else if (st == 3'd5 && op == OP_CHIP_ERASE) begin
					s.data = {8'h00, `CMD_CHIP_ERASE};
					s.last = 1'b1;
				end else if (st == 3'd5) begin
					s = '{addr: a, data: {8'h00, `CMD_SECTOR_ERASE}, last: 1'b1};
				end
			end
			OP_BYP_EXIT: begin
				s.addr = 19'h00000;
				s.data = (st == 3'd0) ? {8'h00, `CMD_AUTOSELECT}
				                      : {8'h00, `CMD_BYPASS_EXIT2};
				s.last = (st == 3'd1);
			end
			OP_RESET:   s = '{addr: 19'h00000, data: {8'h00, `CMD_RESET}, last: 1'b1};
			OP_SUSPEND: s = '{addr: 19'h00000, data: {8'h00, `CMD_SUSPEND}, last: 1'b1};
			OP_RESUME:  s = '{addr: 19'h00000, data: {8'h00, `CMD_RESUME}, last: 1'b1};
			default:    s.last = 1'b1;
		endcase
		return s;
	endfunction

	// Verify read address: sector bits kept, offset 02 (word) or 04 (byte)
	function automatic logic [`FLASH_ADDR_W-1:0] verifyAddr(input logic bm,
		input logic [`FLASH_ADDR_W-1:0] a);
		logic [`FLASH_ADDR_W-1:0] r;
		r = bm ? (((a >> `SECTOR_LSB_BYTE) << `SECTOR_LSB_BYTE) | `VERIFY_OFS_BYTE)
		       : (((a >> `SECTOR_LSB_WORD) << `SECTOR_LSB_WORD) | `VERIFY_OFS_WORD);
		return r;
	endfunction

	function automatic logic isErase(input op_e op);
		return (op == OP_CHIP_ERASE || op == OP_SECT_ERASE || op == OP_RESUME);
	endfunction

	// ==========================================================
	// Request decode
	always_comb begin
		seq         = seqStep(cur.op, step, bypassMode, byteMode, cur.addr, cur.data);
		// Suspend is only offered while a sector erase is being polled
		takeSuspend = (state == S_ISSUE) && (phase == PH_POLL) && eraseActive
		            && !suspendedMode && (cur.op != OP_CHIP_ERASE) && (cur.op != OP_PROGRAM)
		            && cmdValid && (cmd.op == OP_SUSPEND);
		cmdReady    = (state == S_IDLE) || takeSuspend;
		// Mode legality; bypass allows only program, exit and reads
		refuse = (bypassMode && !(cmd.op == OP_PROGRAM || cmd.op == OP_BYP_EXIT
		                          || cmd.op == OP_READ))
		       || (cmd.op == OP_SUSPEND)
		       || (cmd.op == OP_RESUME && !suspendedMode)
		       || (suspendedMode && (cmd.op == OP_CHIP_ERASE
		                             || cmd.op == OP_SECT_ERASE));
		busReqValid = (state == S_ISSUE) && !takeSuspend;
		busReq.write = (phase == PH_WR) || (phase == PH_RESET);
		busReq.addr  = cur.addr;
		busReq.data  = seq.data;
		case (phase)
			PH_WR:    busReq.addr = seq.addr;
			PH_FINAL: busReq.addr = (cur.op == OP_VERIFY) ? verifyAddr(byteMode, cur.addr)
			                                               : cur.addr;
			PH_RESET: begin
				busReq.addr = 19'h00000;
				busReq.data = {8'h00, `CMD_RESET};
			end
			default:  busReq.addr = cur.addr;
		endcase
	end

	// ==========================================================
	// Ready/busy pin crosses in through two flops
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rbMeta     <= 1'b1;
			rbSync     <= 1'b1;
			busyStatus <= 1'b0;
		end else begin
			rbMeta     <= readyBusyN;
			rbSync     <= rbMeta;
			busyStatus <= !rbSync;
		end
	end

	// ==========================================================
	// Sequencer; polling starts only after the last write strobe
	// has risen, which is when status becomes meaningful
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state         <= S_IDLE;
			phase         <= PH_WR;
			step          <= 3'd0;
			cur           <= '{op: OP_READ, addr: 19'h00000, data: 16'h0000};
			expectBit     <= 1'b1;
			sawTimeout    <= 1'b0;
			eraseActive   <= 1'b0;
			bypassMode    <= 1'b0;
			suspendedMode <= 1'b0;
			rspValid      <= 1'b0;
			rsp           <= '{data: 16'h0000, fail: 1'b0};
		end else begin
			rspValid <= 1'b0;
			case (state)
				S_IDLE: begin
					if (cmdValid) begin
						cur        <= cmd;
						step       <= 3'd0;
						sawTimeout <= 1'b0;
						expectBit  <= (cmd.op == OP_PROGRAM) ? cmd.data[`POLL_BIT] : 1'b1;
						phase      <= (cmd.op == OP_READ) ? PH_FINAL : PH_WR;
						if (refuse) begin
							rspValid <= 1'b1;
							rsp      <= '{data: 16'h0000, fail: 1'b1};
						end else begin
							state <= S_ISSUE;
						end
					end
				end
				S_ISSUE: begin
					if (takeSuspend) begin
						cur.op    <= OP_SUSPEND;
						phase     <= PH_WR;
						step      <= 3'd0;
						expectBit <= 1'b1;
					end else if (busReqReady) begin
						state <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (busDone) begin
						state <= S_ISSUE;
						case (phase)
							PH_WR: begin
								if (!seq.last) begin
									step <= step + 3'd1;
								end else begin
									case (cur.op)
										OP_AUTOSEL, OP_VERIFY: phase <= PH_FINAL;
										OP_PROGRAM, OP_SUSPEND: phase <= PH_POLL;
										OP_CHIP_ERASE, OP_SECT_ERASE, OP_RESUME: begin
											phase         <= PH_POLL;
											eraseActive   <= 1'b1;
											suspendedMode <= 1'b0;
										end
										default: begin
											// Mode changes take effect once written
											if (cur.op == OP_BYP_ENTER) bypassMode <= 1'b1;
											if (cur.op == OP_BYP_EXIT) bypassMode <= 1'b0;
											state    <= S_IDLE;
											rspValid <= 1'b1;
											rsp      <= '{data: 16'h0000, fail: 1'b0};
										end
									endcase
								end
							end
							PH_POLL: begin
								if (busRd[`POLL_BIT] == expectBit) begin
									// Other bits may lag the polling bit
									phase <= PH_CONFIRM;
								end else if (busRd[`TIMEOUT_BIT] && sawTimeout) begin
									phase <= PH_RESET;
								end else begin
									sawTimeout <= busRd[`TIMEOUT_BIT];
								end
							end
							PH_CONFIRM: begin
								if (cur.op == OP_SUSPEND) begin
									suspendedMode <= 1'b1;
								end else if (isErase(cur.op)) begin
									eraseActive <= 1'b0;
								end
								state    <= S_IDLE;
								rspValid <= 1'b1;
								rsp      <= '{data: busRd, fail: 1'b0};
							end
							PH_RESET: begin
								if (isErase(cur.op)) begin
									eraseActive   <= 1'b0;
									suspendedMode <= 1'b0;
								end
								state    <= S_IDLE;
								rspValid <= 1'b1;
								rsp      <= '{data: 16'h0000, fail: 1'b1};
							end
							default: begin
								// Plain read, identification or verify data
								state    <= S_IDLE;
								rspValid <= 1'b1;
								rsp      <= '{data: busRd, fail: 1'b0};
							end
						endcase
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin cycle engine
	flash_bus_cycle u_cycle (
		.core_clk  (core_clk),
		.rst       (rst),
		.reqValid  (busReqValid),
		.req       (busReq),
		.reqReady  (busReqReady),
		.doneValid (busDone),
		.rdData    (busRd),
		.flashAddr (flashAddr),
		.dqIn      (dqIn),
		.dqOut     (dqOut),
		.dqOe      (dqOe),
		.ceN       (ceN),
		.weN       (weN),
		.oeN       (oeN)
	);

endmodule
`default_nettype wire

// *** rtl/flash_host_cfg.svh ***
// Timing counts, command codes and address constants for the flash host controller
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// ==========================================================
// Widths
`define FLASH_ADDR_W      19
`define FLASH_DATA_W      16

// ==========================================================
// Clock and bus timing (times in ns, counts rounded up)
`define CLK_PERIOD_NS     8
`define CYC_MIN(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WP_NS           35
`define T_WPH_NS          30
`define T_ACC_NS          70
`define WP_CYC            `CYC_MIN(`T_WP_NS)
`define WPH_CYC           `CYC_MIN(`T_WPH_NS)
`define SYNC_CYC          2
`define RD_CYC            (`CYC_MIN(`T_ACC_NS) + `SYNC_CYC)

// ==========================================================
// Unlock and command addresses (word mode, byte mode)
`define ADR_UNLOCK1_WORD  19'h00555
`define ADR_UNLOCK1_BYTE  19'h00AAA
`define ADR_UNLOCK2_WORD  19'h002AA
`define ADR_UNLOCK2_BYTE  19'h00555
`define SECTOR_LSB_WORD   12
`define SECTOR_LSB_BYTE   13
`define VERIFY_OFS_WORD   19'h00002
`define VERIFY_OFS_BYTE   19'h00004

// ==========================================================
// Command codes (upper data byte driven zero)
`define CMD_UNLOCK1       8'hAA
`define CMD_UNLOCK2       8'h55
`define CMD_AUTOSELECT    8'h90
`define CMD_PROGRAM       8'hA0
`define CMD_BYPASS        8'h20
`define CMD_BYPASS_EXIT2  8'h00
`define CMD_ERASE_SETUP   8'h80
`define CMD_CHIP_ERASE    8'h10
`define CMD_SECTOR_ERASE  8'h30
`define CMD_RESET         8'hF0
`define CMD_SUSPEND       8'hB0
`define CMD_RESUME        8'h30

// ==========================================================
// Status bit positions
`define POLL_BIT          7
`define TIMEOUT_BIT       5

`endif

// *** rtl/flash_host_pkg.sv ***
// Types shared by the flash host controller and its bus cycle engine
`include "flash_host_cfg.svh"
package flash_host_pkg;

	// ==========================================================
	// User operations
	typedef enum logic [3:0] {
		OP_READ       = 4'h0,
		OP_RESET      = 4'h1,
		OP_AUTOSEL    = 4'h2,
		OP_VERIFY     = 4'h3,
		OP_PROGRAM    = 4'h4,
		OP_BYP_ENTER  = 4'h5,
		OP_BYP_EXIT   = 4'h6,
		OP_CHIP_ERASE = 4'h7,
		OP_SECT_ERASE = 4'h8,
		OP_SUSPEND    = 4'h9,
		OP_RESUME     = 4'hA
	} op_e;

	// ==========================================================
	// Carriers
	typedef struct packed {
		op_e                      op;
		logic [`FLASH_ADDR_W-1:0] addr;
		logic [`FLASH_DATA_W-1:0] data;
	} cmd_s;

	typedef struct packed {
		logic [`FLASH_DATA_W-1:0] data;
		logic                     fail;
	} rsp_s;

	typedef struct packed {
		logic                     write;
		logic [`FLASH_ADDR_W-1:0] addr;
		logic [`FLASH_DATA_W-1:0] data;
	} bus_req_s;

	typedef struct packed {
		logic [`FLASH_ADDR_W-1:0] addr;
		logic [`FLASH_DATA_W-1:0] data;
		logic                     last;
	} seq_s;

endpackage

// *** rtl/flash_bus_cycle.sv ***
// Single read or write cycle engine on the asynchronous flash pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_bus_cycle
	import flash_host_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire logic                     reqValid,
	input  wire bus_req_s                 req,
	output logic                          reqReady,
	output logic                          doneValid,
	output logic [`FLASH_DATA_W-1:0]      rdData,
	output logic [`FLASH_ADDR_W-1:0]      flashAddr,
	input  wire logic [`FLASH_DATA_W-1:0] dqIn,
	output logic [`FLASH_DATA_W-1:0]      dqOut,
	output logic                          dqOe,
	output logic                          ceN,
	output logic                          weN,
	output logic                          oeN
);

	// ==========================================================
	// Declarations
	typedef enum logic [2:0] {
		B_IDLE    = 3'b000,
		B_SETUP   = 3'b001,
		B_PULSE   = 3'b010,
		B_HOLD    = 3'b011,
		B_READ    = 3'b100,
		B_RECOVER = 3'b101
	} bstate_e;

	bstate_e                  state;   // Cycle phase
	logic [3:0]               cnt;     // Phase length counter
	logic [`FLASH_DATA_W-1:0] dqMeta;  // First sync stage
	logic [`FLASH_DATA_W-1:0] dqSync;  // Second sync stage

	// Only idle accepts a new cycle
	assign reqReady = (state == B_IDLE);

	// ==========================================================
	// Data pins cross in through two flops
	always_ff @(posedge core_clk) begin
		dqMeta <= dqIn;
		dqSync <= dqMeta;
	end

	// ==========================================================
	// Cycle sequencing; chip select falls first so the write strobe
	// falling edge is the later one and carries the address
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state     <= B_IDLE;
			cnt       <= 4'h0;
			ceN       <= 1'b1;
			weN       <= 1'b1;
			oeN       <= 1'b1;
			dqOe      <= 1'b0;
			dqOut     <= 16'h0000;
			flashAddr <= 19'h00000;
			doneValid <= 1'b0;
			rdData    <= 16'h0000;
		end else begin
			doneValid <= 1'b0;
			case (state)
				B_IDLE: begin
					if (reqValid) begin
						flashAddr <= req.addr;
						dqOut     <= req.data;
						ceN       <= 1'b0;
						if (req.write) begin
							dqOe  <= 1'b1;
							state <= B_SETUP;
						end else begin
							// Read time covers access plus the sync flops
							oeN   <= 1'b0;
							cnt   <= 4'(`RD_CYC - 1);
							state <= B_READ;
						end
					end
				end
				B_SETUP: begin
					weN   <= 1'b0;
					cnt   <= 4'(`WP_CYC - 1);
					state <= B_PULSE;
				end
				B_PULSE: begin
					if (cnt == 4'h0) begin
						weN   <= 1'b1;
						state <= B_HOLD;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				B_HOLD: begin
					// Data stayed one cycle past the rising write strobe
					ceN   <= 1'b1;
					dqOe  <= 1'b0;
					cnt   <= 4'(`WPH_CYC - 1);
					state <= B_RECOVER;
				end
				B_READ: begin
					if (cnt == 4'h0) begin
						rdData <= dqSync;
						oeN    <= 1'b1;
						ceN    <= 1'b1;
						cnt    <= 4'(`WPH_CYC - 1);
						state  <= B_RECOVER;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				B_RECOVER: begin
					if (cnt == 4'h0) begin
						doneValid <= 1'b1;
						state     <= B_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				default: state <= B_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// *** sim/flash_host_assertions.sv ***
// Port-level checks of the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_host_assertions
	import flash_host_pkg::*;
(
	input wire logic                     core_clk,
	input wire logic                     rst,
	input wire logic                     cmdValid,
	input wire logic                     cmdReady,
	input wire cmd_s                     cmd,
	input wire logic                     rspValid,
	input wire rsp_s                     rsp,
	input wire logic                     bypassMode,
	input wire logic                     suspendedMode,
	input wire logic                     busyStatus,
	input wire logic [`FLASH_ADDR_W-1:0] flashAddr,
	input wire logic [`FLASH_DATA_W-1:0] dqOut,
	input wire logic                     dqOe,
	input wire logic                     ceN,
	input wire logic                     weN,
	input wire logic                     oeN,
	input wire logic                     readyBusyN
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic taken; // Request accepted at this edge
	assign taken = cmdValid && cmdReady;
	// ==========================================================
	// Bus cycle shape
	property p_no_fight; !(!weN && !oeN); endproperty
	a_no_fight: assert property (p_no_fight) else $error("write and read strobes low together");
	property p_we_in_ce; !weN |-> !ceN && dqOe; endproperty
	a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe without select or data");
	property p_oe_release; !oeN |-> !dqOe; endproperty
	a_oe_release: assert property (p_oe_release) else $error("host drives data during read");
	property p_wr_hold; !weN && $past(weN) == 1'b0 |-> $stable(flashAddr) && $stable(dqOut); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("address or data moved in write pulse");
	property p_wp_width; $fell(weN) |-> !weN [*5] ##1 weN; endproperty
	a_wp_width: assert property (p_wp_width) else $error("write pulse width wrong");
	// ==========================================================
	// Refusals and status
	property p_resume_refused; taken && cmd.op == OP_RESUME && !suspendedMode
		|-> ##[1:2] rspValid && rsp.fail; endproperty
	a_resume_refused: assert property (p_resume_refused) else $error("resume not refused");
	property p_byp_refused; taken && bypassMode && cmd.op == OP_CHIP_ERASE
		|-> ##[1:2] rspValid && rsp.fail; endproperty
	a_byp_refused: assert property (p_byp_refused) else $error("erase taken in bypass");
	property p_susp_erase; taken && suspendedMode && cmd.op inside {OP_CHIP_ERASE, OP_SECT_ERASE}
		|-> ##[1:2] rspValid && rsp.fail; endproperty
	a_susp_erase: assert property (p_susp_erase) else $error("erase taken while suspended");
	property p_busy; !readyBusyN [*4] |-> busyStatus; endproperty
	a_busy: assert property (p_busy) else $error("busy level not reported");
	c_fail: cover property (rspValid && rsp.fail);
	c_susp: cover property ($rose(suspendedMode));
	c_byp: cover property ($rose(bypassMode));
endmodule
bind flash_host_ctrl flash_host_assertions chk_i (.core_clk, .rst, .cmdValid, .cmdReady, .cmd,
	.rspValid, .rsp, .bypassMode, .suspendedMode, .busyStatus, .flashAddr, .dqOut, .dqOe, .ceN,
	.weN, .oeN, .readyBusyN);
`default_nettype wire

// *** sim/flash_dev_model.sv ***
// Behavioural model of the flash device on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [5:0]  PROT_SECT = 6'h05,
	parameter logic [15:0] DEV_ID    = 16'h7E42 // Arbitrary identification value
)(
	input  wire logic        ceN,
	input  wire logic        weN,
	input  wire logic        oeN,
	input  wire logic        bm,
	input  wire logic        dqOe,
	input  wire logic [18:0] flashAddr,
	input  wire logic [15:0] dqOut,
	output logic      [15:0] dqIn,
	output logic             readyBusyN
);
	logic [15:0] mem [int];                              // Absent words read as erased
	logic [18:0] wa = '0, pl = '0;                       // Write and program addresses
	logic [15:0] pv = '0;                                // Program value
	logic [5:0]  es = '0;                                // Sector under erase
	int          st = 0, ptmr = 0, etmr = 0;             // Unlock step, timers in 10 ns
	logic        idm = 0, pgm = 0, byp = 0, bx = 0, susp = 0, chip = 0, pfl = 0, tg = 0;
	wire logic   wrAct = !ceN && !weN;
	wire logic   rdAct = !ceN && !oeN;
	wire logic   bsy = ptmr > 0 || pfl || (etmr > 0 && !susp);
	assign readyBusyN = !bsy;
	// ==========================================================
	// Command decode, address on later fall, data on earlier rise
	always @(posedge wrAct) wa = flashAddr;
	always @(negedge wrAct) wr(wa, dqOut);
	task automatic wr(input logic [18:0] a, input logic [15:0] dd);
		logic [7:0] d;
		d = dd[7:0];
		if (pgm) begin
			pgm = 0; pl = a; pv = dd; ptmr = 40;
		end else if (d == 8'hF0 && (pfl || !bsy)) begin
			st = 0; idm = 0; pfl = 0; ptmr = 0;
		end else if (bsy) begin // Only suspend can reach a running erase
			if (d == 8'hB0 && etmr > 0 && ptmr == 0 && !chip) susp = 1;
		end else if (byp) begin
			if (bx && d == 8'h00) byp = 0;
			bx = d == 8'h90;
			pgm = d == 8'hA0;
		end else if (susp && st == 0 && d == 8'h30) susp = 0;
		else case (st)
			0, 3: st = (11'(a >> bm) == 11'h555 && d == 8'hAA) ? st + 1 : 0;
			1, 4: st = (11'(a >> bm) == 11'h2AA && d == 8'h55) ? st + 1 : 0;
			2: begin
				st = 0; idm = d == 8'h90;
				pgm = d == 8'hA0;
				if (d == 8'h20 && !susp) byp = 1;
				if (d == 8'h80 && !susp) st = 3;
			end
			default: begin
				st = 0; chip = d == 8'h10; es = a[17:12];
				if (chip || d == 8'h30) etmr = 400;
			end
		endcase
	endtask
	// ==========================================================
	// Embedded algorithms; erase time freezes while suspended
	always #10 begin
		if (ptmr > 0 && --ptmr == 0) begin
			if (((mem.exists(pl) ? mem[pl] : 16'hFFFF) & pv) != pv) pfl = 1;
			else if (pl[17:12] != PROT_SECT) mem[pl] = pv;
		end
		if (etmr > 0 && !susp && --etmr == 0)
			for (int k = 0; k < (1 << 18); k++)
				if ((chip || k[17:12] == es) && k[17:12] != PROT_SECT) mem.delete(k);
	end
	always @(negedge rdAct) if (bsy) tg = !tg;
	function automatic logic [15:0] rdv(input logic [18:0] a);
		if (ptmr > 0 || pfl) return {8'h00, !pv[7], tg, pfl, 5'h00};
		if (etmr > 0 && (!susp || a[17:12] == es)) return {8'h00, susp, tg, 6'h00};
		if (idm) return a[11:0] == 12'h002 ? {15'h0000, a[17:12] == PROT_SECT} : DEV_ID;
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	// Resolved data wire; a released bus keeps changing so stale values never pass
	always #4 begin
		if (dqOe) dqIn = dqOut;
		else if (rdAct) dqIn = rdv(flashAddr);
		else dqIn = ~dqIn;
	end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the flash host controller against the device model
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"
module tb_top
	import flash_host_pkg::*;
;
	localparam logic [15:0] ID = 16'h7E42; // Arbitrary identification value
	logic        core_clk = 1'b0;
	logic        rst = 1'b1, bm = 1'b0;
	logic        cmdValid = 1'b0;
	cmd_s        cmd = '0;
	rsp_s        rsp, r;
	logic        cmdReady, rspValid, bypassMode, suspendedMode, busyStatus;
	logic        dqOe, ceN, weN, oeN, readyBusyN;
	logic [18:0] flashAddr;
	logic [15:0] dqIn, dqOut;
	int          n_mismatch = 0, compares = 0, cyc = 0;
	flash_host_ctrl DUT (.core_clk, .rst, .cmdValid, .cmdReady, .cmd, .byteMode(bm), .rspValid,
		.rsp, .bypassMode, .suspendedMode, .busyStatus, .flashAddr, .dqIn, .dqOut, .dqOe, .ceN,
		.weN, .oeN, .readyBusyN);
	flash_dev_model #(.DEV_ID(ID)) dev (.ceN, .weN, .oeN, .dqOe, .flashAddr, .dqOut, .dqIn,
		.readyBusyN, .bm);
	// ==========================================================
	// Clock and hang guard
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc == 20000) begin
		n_mismatch++;
		print_verdict();
	end
	// ==========================================================
	// Access tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic req(input op_e o, input logic [18:0] a, input logic [15:0] d);
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmd <= '{o, a, d};
		do @(posedge core_clk); while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
	endtask
	// Whole operation; checks only the failure flag
	task automatic run(input op_e o, input logic [18:0] a, input logic [15:0] d, input logic ef);
		req(o, a, d);
		do @(posedge core_clk); while (rspValid !== 1'b1);
		r = rsp;
		chk({15'h0000, r.fail}, {15'h0000, ef});
	endtask
	task automatic rd(input logic [18:0] a, input logic [15:0] exp);
		run(OP_READ, a, 16'h0000, 1'b0);
		chk(r.data, exp);
	endtask
	task automatic print_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(19'h01234, 16'hFFFF);
		run(OP_PROGRAM, 19'h01234, 16'h5A3C, 1'b0);
		chk(r.data, 16'h5A3C);
		rd(19'h01234, 16'h5A3C);
		run(OP_PROGRAM, 19'h01234, 16'hFFFF, 1'b1);
		rd(19'h01234, 16'h5A3C);
		bm <= 1'b1;
		run(OP_AUTOSEL, 19'h00001, 16'h0000, 1'b0);
		chk(r.data, ID);
		bm <= 1'b0;
		run(OP_VERIFY, 19'h05000, 16'h0000, 1'b0);
		chk(r.data, 16'h0001);
		run(OP_VERIFY, 19'h01000, 16'h0000, 1'b0);
		chk(r.data, 16'h0000);
		run(OP_RESET, 19'h00000, 16'h0000, 1'b0);
		rd(19'h01234, 16'h5A3C);
		run(OP_RESUME, 19'h00000, 16'h0000, 1'b1);
		run(OP_SUSPEND, 19'h00000, 16'h0000, 1'b1);
		run(OP_BYP_ENTER, 19'h00000, 16'h0000, 1'b0);
		chk({15'h0000, bypassMode}, 16'h0001);
		run(OP_PROGRAM, 19'h03000, 16'h00C3, 1'b0);
		run(OP_CHIP_ERASE, 19'h03000, 16'h0000, 1'b1);
		run(OP_BYP_EXIT, 19'h00000, 16'h0000, 1'b0);
		chk({15'h0000, bypassMode}, 16'h0000);
		rd(19'h03000, 16'h00C3);
		req(OP_SECT_ERASE, 19'h01000, 16'h0000);
		run(OP_SUSPEND, 19'h01000, 16'h0000, 1'b0);
		chk({15'h0000, r.data[7]}, 16'h0001);
		chk({15'h0000, suspendedMode}, 16'h0001);
		chk({15'h0000, busyStatus}, 16'h0000);
		run(OP_SECT_ERASE, 19'h02000, 16'h0000, 1'b1);
		run(OP_PROGRAM, 19'h02000, 16'h1111, 1'b0);
		rd(19'h02000, 16'h1111);
		run(OP_RESUME, 19'h01000, 16'h0000, 1'b0);
		chk(r.data, 16'hFFFF);
		rd(19'h01234, 16'hFFFF);
		rd(19'h02000, 16'h1111);
		run(OP_CHIP_ERASE, 19'h03000, 16'h0000, 1'b0);
		rd(19'h02000, 16'hFFFF);
		print_verdict();
	end
endmodule
`default_nettype wire
